// ==== rtl/smsc_pkg.sv ====
package smsc_pkg;
  // Switch geometry
  localparam int LANES = 4;
  localparam int LINES = 16;
  localparam int SEL_W = 4;
  localparam int KIND_W = 2;
  localparam int CFG_W = 8;

  // Register bus shape
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int IDX_W = 6;
  localparam int IDX_LSB = 2;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_FAST = 6'h00;
  localparam logic [IDX_W-1:0] IDX_SIDE = 6'h01;
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h02;

  // Field layout of both route configuration registers
  localparam int BIT_ON = 6;
  localparam int KIND_LSB = 4;
  localparam int PICK_LSB = 0;

  // Switching mode encodings
  localparam logic [KIND_W-1:0] KIND_QUAD = 2'h0;
  localparam logic [KIND_W-1:0] KIND_DUAL = 2'h1;
  localparam logic [KIND_W-1:0] KIND_SINGLE = 2'h2;
  localparam logic [KIND_W-1:0] KIND_ILLEGAL = 2'h3;

  // Reset values: enabled, quad mode, source A
  localparam logic [CFG_W-1:0] FAST_RESET = 8'h40;
  localparam logic [CFG_W-1:0] SIDE_RESET = 8'h40;

  // Status register bits
  localparam int ST_STANDBY = 0;
  localparam int ST_ISOLATED = 1;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : smsc_pkg

// ==== rtl/smsc_mode_reg.sv ====
`timescale 1ns/1ps
module smsc_mode_reg
  import smsc_pkg::*;
#(
  parameter logic [CFG_W-1:0] RESET_VAL = FAST_RESET
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic [CFG_W-1:0] i_data,
  output logic o_on,
  output logic [KIND_W-1:0] o_kind,
  output logic [SEL_W-1:0] o_pick
);
  logic on_reg;
  logic [KIND_W-1:0] kind_reg;
  logic [SEL_W-1:0] pick_reg;
  logic [KIND_W-1:0] kind_next;

  assign kind_next = i_data[KIND_LSB +: KIND_W];

  // Enable and source pick take any written value
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      on_reg <= RESET_VAL[BIT_ON];
      pick_reg <= RESET_VAL[PICK_LSB +: SEL_W];
    end else if (i_wr) begin
      on_reg <= i_data[BIT_ON];
      pick_reg <= i_data[PICK_LSB +: SEL_W];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      kind_reg <= RESET_VAL[KIND_LSB +: KIND_W];
    end else if (i_wr && (kind_next != KIND_ILLEGAL)) begin
      kind_reg <= kind_next;
    end
  end

  assign o_on = on_reg;
  assign o_kind = kind_reg;
  assign o_pick = pick_reg;
endmodule : smsc_mode_reg

// ==== rtl/smsc_route.sv ====
`timescale 1ns/1ps
module smsc_route
  import smsc_pkg::*;
#(
  parameter bit SIDE_DUAL = 1'b0
) (
  input wire logic i_on,
  input wire logic [KIND_W-1:0] i_kind,
  input wire logic [SEL_W-1:0] i_pick,
  output logic [LANES-1:0] o_lane_on,
  output logic [LANES*SEL_W-1:0] o_lane_src
);
  // Decode enable, mode and pick into per-lane source indices
  always_comb begin
    logic [SEL_W-1:0] lo;
    logic [SEL_W-1:0] hi;
    lo = '0;
    hi = '0;
    o_lane_on = '0;
    o_lane_src = '0;
    if (i_on) begin
      unique case (i_kind)
        KIND_QUAD: begin
          for (int k = 0; k < LANES; k++) begin
            o_lane_on[k] = 1'b1;
            o_lane_src[k*SEL_W +: SEL_W] = {i_pick[1:0], 2'(k)};
          end
        end
        KIND_DUAL: begin
          if (SIDE_DUAL) begin
            lo = {1'b0, i_pick[2], i_pick[1:0]};
            hi = {1'b1, i_pick[2], i_pick[1:0]};
          end else begin
            lo = {i_pick[2:1], i_pick[0], 1'b0};
            hi = {i_pick[2:1], i_pick[0], 1'b1};
          end
          o_lane_on = '1;
          o_lane_src = {hi, hi, lo, lo};
        end
        // one of sixteen to all lanes
        KIND_SINGLE: begin
          o_lane_on = '1;
          o_lane_src = {i_pick, i_pick, i_pick, i_pick};
        end
        default: begin
          o_lane_on = '0;
        end
      endcase
    end
  end
endmodule : smsc_route

// ==== rtl/smsc_top.sv ====
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module smsc_top
  import smsc_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic [AXI_ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [AXI_DATA_W-1:0] I_WDATA,
  input wire logic [AXI_DATA_W/8-1:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [AXI_ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [AXI_DATA_W-1:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [LINES-1:0] I_FAST_IN,
  output logic [LANES-1:0] O_FAST_OUT,
  output logic [LANES-1:0] O_FAST_OUT_EN,
  output logic O_FAST_STANDBY,
  input wire logic [LINES-1:0] I_SIDE_LINE_IN,
  output logic [LINES-1:0] O_SIDE_LINE_OUT,
  output logic [LINES-1:0] O_SIDE_LINE_OE,
  input wire logic [LANES-1:0] I_SIDE_COMMON_LINES_IN,
  output logic [LANES-1:0] O_SIDE_COMMON_LINES_OUT,
  output logic [LANES-1:0] O_SIDE_COMMON_LINES_OE
);
  // Write channel state
  logic aw_held_reg;
  logic [IDX_W-1:0] aw_idx_reg;
  logic w_held_reg;
  logic [CFG_W-1:0] w_data_reg;
  logic w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic wr_fire;
  logic fast_wr;
  logic side_wr;

  // Read channel state
  logic rvalid_reg;
  logic [AXI_DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [IDX_W-1:0] ar_idx;
  logic [AXI_DATA_W-1:0] rd_mux;
  logic [1:0] rd_resp;

  // Register fields
  logic fast_on;
  logic [KIND_W-1:0] fast_kind;
  logic [SEL_W-1:0] fast_pick;
  logic side_on;
  logic [KIND_W-1:0] side_kind;
  logic [SEL_W-1:0] side_pick;

  // Decoder results
  logic [LANES-1:0] fast_lane_on;
  logic [LANES*SEL_W-1:0] fast_src;
  logic [LANES-1:0] side_lane_on;
  logic [LANES*SEL_W-1:0] side_src;

  // Switch output flip-flops and return-path next values
  logic [LANES-1:0] fast_out_reg;
  logic [LANES-1:0] fast_en_reg;
  logic fast_standby_reg;
  logic [LANES-1:0] common_out_reg;
  logic [LANES-1:0] common_oe_reg;
  logic [LINES-1:0] line_out_reg;
  logic [LINES-1:0] line_oe_reg;
  logic [LINES-1:0] line_out_next;
  logic [LINES-1:0] line_oe_next;

  // Address and data are each taken once, then held until the pair is done
  assign O_AWREADY = !aw_held_reg && !bvalid_reg;
  assign O_WREADY = !w_held_reg && !bvalid_reg;
  assign wr_fire = aw_held_reg && w_held_reg;
  // Only the low byte lane carries register bits
  assign fast_wr = wr_fire && w_strb_reg && (aw_idx_reg == IDX_FAST);
  assign side_wr = wr_fire && w_strb_reg && (aw_idx_reg == IDX_SIDE);

  // Write address capture
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      aw_held_reg <= 1'b0;
      aw_idx_reg <= '0;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end else if (I_AWVALID && O_AWREADY) begin
      aw_held_reg <= 1'b1;
      aw_idx_reg <= I_AWADDR[IDX_LSB +: IDX_W];
    end
  end

  // Write data capture
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= 1'b0;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end else if (I_WVALID && O_WREADY) begin
      w_held_reg <= 1'b1;
      w_data_reg <= I_WDATA[CFG_W-1:0];
      w_strb_reg <= I_WSTRB[0];
    end
  end

  // Write response; unmapped indices answer with a slave error
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      if ((aw_idx_reg == IDX_FAST) || (aw_idx_reg == IDX_SIDE) ||
          (aw_idx_reg == IDX_STATUS)) begin
        bresp_reg <= RESP_OKAY;
      end else begin
        bresp_reg <= RESP_SLVERR;
      end
    end else if (I_BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign O_BVALID = bvalid_reg;
  assign O_BRESP = bresp_reg;

  smsc_mode_reg #(
    .RESET_VAL(FAST_RESET)
  ) u_fast_cfg (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_wr(fast_wr),
    .i_data(w_data_reg),
    .o_on(fast_on),
    .o_kind(fast_kind),
    .o_pick(fast_pick)
  );

  smsc_mode_reg #(
    .RESET_VAL(SIDE_RESET)
  ) u_side_cfg (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_wr(side_wr),
    .i_data(w_data_reg),
    .o_on(side_on),
    .o_kind(side_kind),
    .o_pick(side_pick)
  );

  // Read decode; reserved bit 7 and upper bits read zero
  assign ar_idx = I_ARADDR[IDX_LSB +: IDX_W];
  always_comb begin
    rd_mux = '0;
    rd_resp = RESP_OKAY;
    if (ar_idx == IDX_FAST) begin
      rd_mux = AXI_DATA_W'({1'b0, fast_on, fast_kind, fast_pick});
    end else if (ar_idx == IDX_SIDE) begin
      rd_mux = AXI_DATA_W'({1'b0, side_on, side_kind, side_pick});
    end else if (ar_idx == IDX_STATUS) begin
      rd_mux[ST_STANDBY] = fast_standby_reg;
      rd_mux[ST_ISOLATED] = !(|common_oe_reg);
    end else begin
      rd_resp = RESP_SLVERR;
    end
  end

  // Read answer, one cycle after the address is taken
  assign O_ARREADY = !rvalid_reg;
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (I_ARVALID && O_ARREADY) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_resp;
    end else if (I_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign O_RVALID = rvalid_reg;
  assign O_RDATA = rdata_reg;
  assign O_RRESP = rresp_reg;

  // Same decoder, different dual-mode pairing
  smsc_route #(
    .SIDE_DUAL(1'b0)
  ) u_fast_route (
    .i_on(fast_on),
    .i_kind(fast_kind),
    .i_pick(fast_pick),
    .o_lane_on(fast_lane_on),
    .o_lane_src(fast_src)
  );

  smsc_route #(
    .SIDE_DUAL(1'b1)
  ) u_side_route (
    .i_on(side_on),
    .i_kind(side_kind),
    .i_pick(side_pick),
    .o_lane_on(side_lane_on),
    .o_lane_src(side_src)
  );

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      fast_out_reg <= '0;
      fast_en_reg <= '0;
      fast_standby_reg <= 1'b1;
    end else begin
      for (int k = 0; k < LANES; k++) begin
        fast_out_reg[k] <= fast_lane_on[k] && I_FAST_IN[fast_src[k*SEL_W +: SEL_W]];
      end
      fast_en_reg <= fast_lane_on;
      fast_standby_reg <= !fast_on;
    end
  end

  // Return path: lowest connected common line wins a shared side line
  always_comb begin
    line_out_next = '0;
    line_oe_next = '0;
    for (int j = 0; j < LINES; j++) begin
      for (int k = LANES - 1; k >= 0; k--) begin
        if (side_lane_on[k] && (side_src[k*SEL_W +: SEL_W] == SEL_W'(j))) begin
          line_oe_next[j] = 1'b1;
          line_out_next[j] = I_SIDE_COMMON_LINES_IN[k];
        end
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      common_out_reg <= '0;
      common_oe_reg <= '0;
      line_out_reg <= '0;
      line_oe_reg <= '0;
    end else begin
      for (int k = 0; k < LANES; k++) begin
        common_out_reg[k] <= side_lane_on[k] && I_SIDE_LINE_IN[side_src[k*SEL_W +: SEL_W]];
      end
      common_oe_reg <= side_lane_on;
      line_out_reg <= line_out_next;
      line_oe_reg <= line_oe_next;
    end
  end

  assign O_FAST_OUT = fast_out_reg;
  assign O_FAST_OUT_EN = fast_en_reg;
  assign O_FAST_STANDBY = fast_standby_reg;
  assign O_SIDE_COMMON_LINES_OUT = common_out_reg;
  assign O_SIDE_COMMON_LINES_OE = common_oe_reg;
  assign O_SIDE_LINE_OUT = line_out_reg;
  assign O_SIDE_LINE_OE = line_oe_reg;

  // Checks on configuration, routing and the write response
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);

  sequence s_fast_off_write;
    fast_wr && !w_data_reg[BIT_ON];
  endsequence

  sequence s_fast_bad_write;
    fast_wr && (w_data_reg[KIND_LSB +: KIND_W] == KIND_ILLEGAL);
  endsequence

  sequence s_side_bad_write;
    side_wr && (w_data_reg[KIND_LSB +: KIND_W] == KIND_ILLEGAL);
  endsequence

  a_fast_standby_off: assert property (!fast_on |=> (O_FAST_STANDBY && (O_FAST_OUT_EN == '0)))
    else $error("fast lanes active while disabled");
  a_fast_active_on: assert property (fast_on |=> (!O_FAST_STANDBY && (O_FAST_OUT_EN == '1)))
    else $error("fast lanes not active while enabled");
  a_fast_kind_kept: assert property (s_fast_bad_write |=> $stable(fast_kind))
    else $error("illegal fast mode changed the held mode");
  a_fast_kind_legal: assert property (fast_kind != KIND_ILLEGAL)
    else $error("fast mode holds illegal code");
  a_fast_quad_map: assert property ((fast_on && (fast_kind == KIND_QUAD)) |->
      (fast_src == {fast_pick[1:0], 2'h3, fast_pick[1:0], 2'h2,
                    fast_pick[1:0], 2'h1, fast_pick[1:0], 2'h0}))
    else $error("quad fast mapping wrong");
  a_fast_dual_map: assert property ((fast_on && (fast_kind == KIND_DUAL)) |->
      ((fast_src[SEL_W-1:0] == {fast_pick[2:0], 1'b0}) &&
       (fast_src[3*SEL_W +: SEL_W] == {fast_pick[2:0], 1'b1})))
    else $error("dual fast mapping wrong");
  a_fast_single_data: assert property ((fast_on && (fast_kind == KIND_SINGLE)) |=>
      (O_FAST_OUT == {LANES{$past(I_FAST_IN[fast_pick])}}))
    else $error("single fast output not the picked channel");
  a_side_isolated: assert property (!side_on |=>
      ((O_SIDE_COMMON_LINES_OE == '0) && (O_SIDE_LINE_OE == '0)))
    else $error("side lines connected while disabled");
  a_side_kind_kept: assert property (s_side_bad_write |=> $stable(side_kind))
    else $error("illegal side mode changed the held mode");
  a_side_kind_legal: assert property (side_kind != KIND_ILLEGAL)
    else $error("side mode holds illegal code");
  a_side_quad_data: assert property ((side_on && (side_kind == KIND_QUAD)) |=>
      (O_SIDE_COMMON_LINES_OUT == $past(I_SIDE_LINE_IN[{side_pick[1:0], 2'h0} +: LANES])))
    else $error("quad side output not the picked source");
  a_side_dual_map: assert property ((side_on && (side_kind == KIND_DUAL)) |->
      ((side_src[SEL_W-1:0] == {1'b0, side_pick[2:0]}) &&
       (side_src[2*SEL_W +: SEL_W] == {1'b1, side_pick[2:0]})))
    else $error("dual side mapping wrong");
  // single side to every common line
  a_side_single_map: assert property ((side_on && (side_kind == KIND_SINGLE)) |->
      (side_src == {side_pick, side_pick, side_pick, side_pick}))
    else $error("single side mapping wrong");
  // write reaches the pins two edges later
  a_write_reconfig: assert property (s_fast_off_write |=> ##1
      (O_FAST_STANDBY && (O_FAST_OUT_EN == '0)))
    else $error("fast disable write did not take effect");
  // Write response follows the address and data pair
  a_bus_write_resp: assert property (wr_fire |=> (O_BVALID && !O_AWREADY && !O_WREADY))
    else $error("write response missing after address and data");
endmodule : smsc_top

// ==== test/smsc_host_model.sv ====
`timescale 1ns/1ps
module smsc_host_model
  import smsc_pkg::*;
(
  input wire logic i_clk,
  output logic [AXI_ADDR_W-1:0] o_awaddr,
  output logic o_awvalid,
  input wire logic i_awready,
  output logic [AXI_DATA_W-1:0] o_wdata,
  output logic [AXI_DATA_W/8-1:0] o_wstrb,
  output logic o_wvalid,
  input wire logic i_wready,
  input wire logic [1:0] i_bresp,
  input wire logic i_bvalid,
  output logic o_bready,
  output logic [AXI_ADDR_W-1:0] o_araddr,
  output logic o_arvalid,
  input wire logic i_arready,
  input wire logic [AXI_DATA_W-1:0] i_rdata,
  input wire logic [1:0] i_rresp,
  input wire logic i_rvalid,
  output logic o_rready
);
  // Quiet bus from time zero
  initial begin
    o_awaddr = '0;
    o_awvalid = 1'b0;
    o_wdata = '0;
    o_wstrb = '0;
    o_wvalid = 1'b0;
    o_bready = 1'b0;
    o_araddr = '0;
    o_arvalid = 1'b0;
    o_rready = 1'b0;
  end

  // One write; each channel dropped only at its own handshake edge
  task automatic write_reg(input logic [AXI_ADDR_W-1:0] addr, input logic [CFG_W-1:0] data,
                           output logic [1:0] resp);
    bit aw_done;
    bit w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge i_clk);
    o_awaddr <= addr;
    o_awvalid <= 1'b1;
    o_wdata <= AXI_DATA_W'(data);
    o_wstrb <= 4'h1;
    o_wvalid <= 1'b1;
    o_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge i_clk);
      if (!aw_done && i_awready) begin
        o_awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && i_wready) begin
        o_wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    // No fixed latency assumed; the watchdog ends a hang
    do @(posedge i_clk); while (!i_bvalid);
    resp = i_bresp;
    o_bready <= 1'b0;
  endtask : write_reg

  // One read; rready held until rvalid is seen
  task automatic read_reg(input logic [AXI_ADDR_W-1:0] addr, output logic [AXI_DATA_W-1:0] data,
                          output logic [1:0] resp);
    @(posedge i_clk);
    o_araddr <= addr;
    o_arvalid <= 1'b1;
    o_rready <= 1'b1;
    do @(posedge i_clk); while (!i_arready);
    o_arvalid <= 1'b0;
    do @(posedge i_clk); while (!i_rvalid);
    data = i_rdata;
    resp = i_rresp;
    o_rready <= 1'b0;
  endtask : read_reg
endmodule : smsc_host_model

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench
  import smsc_pkg::*;
;
  localparam logic [7:0] A_FAST = {IDX_FAST, 2'h0};
  localparam logic [7:0] A_SIDE = {IDX_SIDE, 2'h0};
  localparam logic [7:0] A_STAT = {IDX_STATUS, 2'h0};
  logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, standby;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, fast_out, fast_en, common_in, common_out, common_oe;
  logic [1:0] bresp, rresp;
  logic [15:0] fast_in, side_in, line_out, line_oe;
  int mismatches = 0;
  int comparisons = 0;

  smsc_top i_dut (.I_CLOCK(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
    .O_RVALID(rvalid), .I_RREADY(rready), .I_FAST_IN(fast_in), .O_FAST_OUT(fast_out),
    .O_FAST_OUT_EN(fast_en), .O_FAST_STANDBY(standby), .I_SIDE_LINE_IN(side_in),
    .O_SIDE_LINE_OUT(line_out), .O_SIDE_LINE_OE(line_oe), .I_SIDE_COMMON_LINES_IN(common_in),
    .O_SIDE_COMMON_LINES_OUT(common_out), .O_SIDE_COMMON_LINES_OE(common_oe));

  smsc_host_model i_host (.i_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid),
    .i_awready(awready), .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid), .i_wready(wready),
    .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready), .o_araddr(araddr),
    .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata), .i_rresp(rresp),
    .i_rvalid(rvalid), .o_rready(rready));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : compare

  // Source channel feeding lane k, worked out from the mapping tables
  function automatic int src_of(input logic [1:0] kind, input logic [3:0] pick, input bit side,
                                input int k);
    if (kind == KIND_SINGLE) return int'(pick);
    if (kind == KIND_QUAD) return int'(pick[1:0]) * 4 + k;
    if (side) return (k < 2 ? int'(pick[2]) : 2 + int'(pick[2])) * 4 + int'(pick[1:0]);
    return int'(pick[2:1]) * 4 + int'(pick[0]) * 2 + (k < 2 ? 0 : 1);
  endfunction : src_of

  // Walks a single high input across all sixteen lines; catches any wrong source
  task automatic check_route(input bit side, input logic [1:0] kind, input logic [3:0] pick);
    logic [15:0] p, oe, back;
    logic [3:0] exp_out;
    int s;
    for (int j = 0; j < 16; j++) begin
      p = 16'h0001 << j;
      oe = '0;
      back = '0;
      for (int k = 3; k >= 0; k--) begin
        s = src_of(kind, pick, side, k);
        exp_out[k] = p[s];
        oe[s] = 1'b1;
        back[s] = p[k];
      end
      @(posedge clk);
      fast_in <= p;
      side_in <= p;
      common_in <= p[3:0];
      repeat (2) @(posedge clk);
      #1;
      if (!side) begin
        compare("fast data", 32'(exp_out), 32'(fast_out));
        compare("fast lanes on", 32'h0f, 32'(fast_en));
      end else begin
        compare("common data", 32'(exp_out), 32'(common_out));
        compare("common enables", 32'h0f, 32'(common_oe));
        compare("line enables", 32'(oe), 32'(line_oe));
        compare("line return", 32'(back), 32'(line_out & line_oe));
      end
    end
  endtask : check_route

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    #1;
    compare("standby after reset", 32'h0, 32'(standby));
    i_host.read_reg(A_FAST, d, r);
    compare("fast config", 32'(FAST_RESET), d);
    i_host.read_reg(A_SIDE, d, r);
    compare("side config", 32'(SIDE_RESET), d);
    i_host.read_reg(A_STAT, d, r);
    compare("status", 32'h0, d);
    // Unmapped place refused on both channels
    i_host.read_reg(8'h3c, d, r);
    compare("unmapped read", {30'h0, RESP_SLVERR}, {d[29:0], r});
    i_host.write_reg(8'h3c, 8'h00, r);
    compare("unmapped write", 32'(RESP_SLVERR), 32'(r));
    $display("test reset done");
  endtask : t_reset

  // All three legal modes and every pick, each write followed by a full sixteen-line route check
  task automatic t_routes(input bit side);
    logic [1:0] r;
    for (int m = 0; m < 3; m++) begin
      for (int c = 0; c < 16; c++) begin
        i_host.write_reg(side ? A_SIDE : A_FAST, {2'b01, 2'(m), 4'(c)}, r);
        compare("write response", 32'(RESP_OKAY), 32'(r));
        check_route(side, 2'(m), 4'(c));
      end
    end
    $display("test routes %0d done", side);
  endtask : t_routes

  // Mode 11 keeps the old mode while pick still updates
  task automatic t_illegal(input bit side);
    logic [31:0] d;
    logic [1:0] r;
    i_host.write_reg(side ? A_SIDE : A_FAST, 8'h55, r);
    i_host.write_reg(side ? A_SIDE : A_FAST, 8'h79, r);
    i_host.read_reg(side ? A_SIDE : A_FAST, d, r);
    compare("mode kept", 32'h59, d);
    check_route(side, KIND_DUAL, 4'h9);
    $display("test illegal %0d done", side);
  endtask : t_illegal

  task automatic t_off;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    fast_in <= 16'hffff;
    side_in <= 16'hffff;
    i_host.write_reg(A_FAST, 8'h00, r);
    i_host.write_reg(A_SIDE, 8'h00, r);
    repeat (2) @(posedge clk);
    #1;
    compare("standby", 32'h1, 32'(standby));
    compare("fast lanes off", 32'h0, {fast_en, fast_out});
    compare("side isolated", 32'h0, {common_oe, line_oe});
    i_host.read_reg(A_STAT, d, r);
    compare("status off", 32'h3, d);
    i_host.write_reg(A_FAST, 8'h40, r);
    repeat (2) @(posedge clk);
    #1;
    compare("standby left", 32'h0f, {standby, fast_en});
    $display("test off done");
  endtask : t_off

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // Main sequence
  initial begin
    rst = 1'b1;
    fast_in = '0;
    side_in = '0;
    common_in = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_routes(1'b0);
    t_routes(1'b1);
    t_illegal(1'b0);
    t_illegal(1'b1);
    t_off();
    complete_run();
  end

  // Watchdog; about eight times the expected run
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    complete_run();
  end
endmodule : testbench
